//--- core/port_power_pkg.sv
// Package: constants and types shared by the port power and overcurrent control logic
`default_nettype none
package port_power_pkg;
    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 7;          // Downstream ports 7..1
    localparam int PORT_LO = 1;            // Lowest port index
    localparam int PORT_HI = 7;            // Highest port index
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    localparam logic PIN_LOW = 1'h0;       // Low voltage level
    localparam logic PIN_HIGH = 1'h1;      // High voltage level
    localparam logic OE_DRIVE = 1'h0;      // Output enable low means driving
    localparam logic OE_RELEASE = 1'h1;    // Output enable high means released
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;    // Core clock rate
    localparam int RENEG_NS = 1000;        // Upstream renegotiation pulse time
    localparam int RENEG_CYC = (RENEG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] RENEG_LOAD = 8'(RENEG_CYC);
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    // ------------------------------------------------------------
    // Upstream connect state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        UP_DETACHED = 3'b001,              // No upstream power
        UP_CONNECTED = 3'b010,             // Connected upstream
        UP_RENEGOTIATE = 3'b100            // Short restart of connect
    } up_state_type;
endpackage
`default_nettype wire

//--- core/pin_sync2.sv
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module pin_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1  // Idle level of each pin
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;             // First stage, read only by second
    logic [WIDTH-1:0] sync_ff;             // Second stage, safe to use

    // Both stages reset to the pin's idle level, so no false edge follows reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- core/port_power_overcurrent_ctl.sv
// Downstream port power enable, overcurrent sense and upstream power detect logic
`default_nettype none
module port_power_overcurrent_ctl
    import port_power_pkg::*;
#(
    parameter int N_PORTS = port_power_pkg::NUM_PORTS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [N_PORTS:1] port_enable,
    input wire logic gang_mode,
    input wire logic [N_PORTS:1] oc_ack,
    input wire logic [N_PORTS:1] port_pin_in,
    output logic [N_PORTS:1] port_pin_out,
    output logic [N_PORTS:1] port_pin_oe_n,
    output logic [N_PORTS:1] port_pullup_en,
    input wire logic shared_power_control_in,
    output logic shared_power_control_out,
    output logic shared_power_control_oe_n,
    output logic shared_pullup_en,
    input wire logic upstream_power_detect,
    output logic upstream_connect,
    output logic upstream_reneg,
    output logic [N_PORTS:1] oc_flag,
    output logic gang_oc_flag
);
    import port_power_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [N_PORTS:1] port_pin_sync;       // Per-port pin level, synchronised
    logic [1:0] misc_raw;                  // Shared pin and detect, raw
    logic [1:0] misc_sync;                 // Shared pin and detect, synchronised

    assign misc_raw = {shared_power_control_in, upstream_power_detect};

    // Every pin passes two flops before any logic looks at it
    pin_sync2 #(.WIDTH(N_PORTS), .RESET_VAL({N_PORTS{PIN_HIGH}})) u_port_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(port_pin_in),
        .sync_out(port_pin_sync)
    );

    // Detect resets low (no power), so after reset a restart starts only once the real detect level reads high
    pin_sync2 #(.WIDTH(2), .RESET_VAL({PIN_HIGH, PIN_LOW})) u_misc_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(misc_raw),
        .sync_out(misc_sync)
    );

    // ------------------------------------------------------------
    // Decoded port power state
    // ------------------------------------------------------------
    logic shared_sync;                     // Shared pin level
    logic detect_sync;                     // Upstream detect level
    logic gang_on;                         // Any port enabled in gang mode
    logic [N_PORTS:1] per_port_on;         // Per-port mode enable
    logic [N_PORTS:1] oc_seen;             // Overcurrent seen this cycle
    logic gang_oc_seen;                    // Shared-pin overcurrent seen

    assign shared_sync = misc_sync[1];
    assign detect_sync = misc_sync[0];
    // Gang power stays on while any port wants power
    assign gang_on = gang_mode & (|port_enable);
    // Per-port pins only steer power outside gang mode
    assign per_port_on = gang_mode ? '0 : port_enable;
    // ------------------------------------------------------------
    // Per-port pin drive and overcurrent flags
    // ------------------------------------------------------------
    logic [N_PORTS:1] oe_n_ff;             // Pin release, registered
    logic [N_PORTS:1] pullup_ff;           // Pull-up enable, registered
    logic [N_PORTS:1] oc_ff;               // Latched overcurrent per port

    genvar p;
    generate
        for (p = PORT_LO; p <= N_PORTS; p++) begin : g_port
            // Released with pull-up when on, else driven low
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    oe_n_ff[p] <= OE_DRIVE;
                    pullup_ff[p] <= 1'b0;
                end else begin
                    oe_n_ff[p] <= per_port_on[p] ? OE_RELEASE : OE_DRIVE;
                    pullup_ff[p] <= per_port_on[p];
                end
            end

            // Sticky flag; a new event wins over the acknowledge
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    oc_ff[p] <= 1'b0;
                end else if (oc_seen[p]) begin
                    oc_ff[p] <= 1'b1;
                end else if (oc_ack[p]) begin
                    oc_ff[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // Driven level is always low; only the enable changes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_pin_out <= '0;
            shared_power_control_out <= PIN_LOW;
        end else begin
            port_pin_out <= '0;
            shared_power_control_out <= PIN_LOW;
        end
    end

    assign port_pin_oe_n = oe_n_ff;
    assign port_pullup_en = pullup_ff;
    assign oc_flag = oc_ff;

    // ------------------------------------------------------------
    // Shared gang power pin
    // ------------------------------------------------------------
    logic shared_oe_n_ff;                  // Shared pin release
    logic shared_pu_ff;                    // Shared pin pull-up
    logic gang_oc_ff;                      // Latched gang overcurrent
    logic [N_PORTS:1] pu_d1_ff;            // Port release, one edge old
    logic [N_PORTS:1] pu_d2_ff;            // Port release, two edges old
    logic sh_d1_ff;                        // Shared release, one edge old
    logic sh_d2_ff;                        // Shared release, two edges old

    // A just-released pin reads low until the synchroniser catches up;
    // sensing that early would flag every enable as an overcurrent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_d1_ff <= '0;
            pu_d2_ff <= '0;
            sh_d1_ff <= 1'b0;
            sh_d2_ff <= 1'b0;
        end else begin
            pu_d1_ff <= pullup_ff;
            pu_d2_ff <= pu_d1_ff;
            sh_d1_ff <= shared_pu_ff;
            sh_d2_ff <= sh_d1_ff;
        end
    end

    // Low on a settled released pin is overcurrent (active low)
    assign oc_seen = pullup_ff & pu_d1_ff & pu_d2_ff & ~port_pin_sync;
    // Same test on the shared pin in gang mode
    assign gang_oc_seen = shared_pu_ff & sh_d1_ff & sh_d2_ff & (shared_sync == PIN_LOW);

    // Shared pin behaves as one port control for all ports
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shared_oe_n_ff <= OE_DRIVE;
            shared_pu_ff <= 1'b0;
        end else begin
            shared_oe_n_ff <= gang_on ? OE_RELEASE : OE_DRIVE;
            shared_pu_ff <= gang_on;
        end
    end

    // Any acknowledge clears gang flag; new event still wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gang_oc_ff <= 1'b0;
        end else if (gang_oc_seen) begin
            gang_oc_ff <= 1'b1;
        end else if (|oc_ack) begin
            gang_oc_ff <= 1'b0;
        end
    end

    assign shared_power_control_oe_n = shared_oe_n_ff;
    assign shared_pullup_en = shared_pu_ff;
    assign gang_oc_flag = gang_oc_ff;

    // ------------------------------------------------------------
    // Upstream connect control
    // ------------------------------------------------------------
    up_state_type state_ff;                // Upstream connect state
    up_state_type nxt_state;               // Next upstream state
    logic [7:0] reneg_cnt_ff;              // Renegotiation pulse timer
    logic [7:0] nxt_reneg_cnt;             // Next timer value
    logic connect_ff;                      // Registered connect output
    logic reneg_ff;                        // Registered renegotiate output
    logic detect_high;                     // Upstream power present

    // Detect is active high: high level means bus power present
    assign detect_high = (detect_sync == PIN_HIGH);

    // Loss of power drops the link; return goes via a short restart,
    // so a host toggle renegotiates without resetting the hub
    always_comb begin
        nxt_state = state_ff;
        nxt_reneg_cnt = reneg_cnt_ff;
        case (state_ff)
            UP_DETACHED: begin
                if (detect_high) begin
                    nxt_state = UP_RENEGOTIATE;
                    nxt_reneg_cnt = RENEG_LOAD;
                end
            end
            UP_RENEGOTIATE: begin
                if (!detect_high) begin
                    nxt_state = UP_DETACHED;
                end else if (reneg_cnt_ff <= CNT_ONE) begin
                    nxt_state = UP_CONNECTED;
                    nxt_reneg_cnt = CNT_ZERO;
                end else begin
                    nxt_reneg_cnt = reneg_cnt_ff - CNT_ONE;
                end
            end
            UP_CONNECTED: begin
                if (!detect_high) begin
                    nxt_state = UP_DETACHED;
                end
            end
            default: begin
                nxt_state = UP_DETACHED;
            end
        endcase
    end

    // State register; only this machine restarts, port state survives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= UP_DETACHED;
            reneg_cnt_ff <= CNT_ZERO;
            connect_ff <= 1'b0;
            reneg_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            reneg_cnt_ff <= nxt_reneg_cnt;
            connect_ff <= (nxt_state == UP_CONNECTED);
            reneg_ff <= (nxt_state == UP_RENEGOTIATE);
        end
    end

    assign upstream_connect = connect_ff;
    assign upstream_reneg = reneg_ff;
endmodule
`default_nettype wire

//--- verification/port_power_overcurrent_ctl_properties.sv
// Checker: port power, overcurrent and upstream detect properties
`default_nettype none
module port_power_props
    import port_power_pkg::*;
#(
    parameter int N_PORTS = 7
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [N_PORTS:1] port_enable,
    input wire logic gang_mode,
    input wire logic [N_PORTS:1] oc_ack,
    input wire logic [N_PORTS:1] port_pin_in,
    input wire logic [N_PORTS:1] port_pin_out,
    input wire logic [N_PORTS:1] port_pin_oe_n,
    input wire logic [N_PORTS:1] port_pullup_en,
    input wire logic shared_power_control_oe_n,
    input wire logic upstream_power_detect,
    input wire logic upstream_connect,
    input wire logic upstream_reneg,
    input wire logic [N_PORTS:1] oc_flag
);
    // ----------------------------------------------------
    // Properties
    // ----------------------------------------------------
    localparam int reneg_last = RENEG_CYC - 1; // Last cycle of renegotiation
    logic [N_PORTS:1] oc_seen; // Pin low on a released port
    assign oc_seen = ~port_pin_in & port_pin_oe_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_release;
        nrst |=> port_pin_oe_n == $past(port_enable & ~{N_PORTS{gang_mode}});
    endproperty
    a_release: assert property (p_release)
        else $error("port drive state wrong");
    property p_pullup;
        port_pullup_en == port_pin_oe_n && port_pin_out == '0;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up or drive level wrong");
    property p_shared;
        nrst |=> shared_power_control_oe_n == $past(gang_mode && (|port_enable));
    endproperty
    a_shared: assert property (p_shared)
        else $error("shared power pin wrong");
    property p_oc_cause;
        ((oc_flag & ~$past(oc_flag)) & $past(port_pin_in, 3)) == '0;
    endproperty
    a_oc_cause: assert property (p_oc_cause)
        else $error("overcurrent flag without low pin");
    property p_oc_set;
        ($past(oc_seen, 1) & $past(oc_seen, 2) & $past(oc_seen, 3) & ~oc_flag) == '0;
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("overcurrent flag missing");
    property p_oc_hold;
        ($past(oc_flag) & ~oc_flag & ~$past(oc_ack)) == '0;
    endproperty
    a_oc_hold: assert property (p_oc_hold)
        else $error("overcurrent flag lost without ack");
    property p_reneg;
        $rose(upstream_reneg) |-> ##reneg_last upstream_reneg ##1
            (!upstream_reneg && upstream_connect);
    endproperty
    a_reneg: assert property (p_reneg)
        else $error("renegotiation length wrong");
    property p_reneg_cause;
        $rose(upstream_reneg) |-> $past(upstream_power_detect, 3);
    endproperty
    a_reneg_cause: assert property (p_reneg_cause)
        else $error("renegotiation without detect");
    property p_detect_low;
        !upstream_power_detect [*4] |-> !upstream_connect && !upstream_reneg;
    endproperty
    a_detect_low: assert property (p_detect_low)
        else $error("connected without upstream power");
    c_oc: cover property ($rose(|oc_flag));
    c_reneg: cover property ($fell(upstream_reneg));
    c_gang: cover property (gang_mode && shared_power_control_oe_n);
endmodule
bind port_power_overcurrent_ctl port_power_props #(.N_PORTS(N_PORTS)) u_props (
    .clk(clk), .nrst(nrst), .port_enable(port_enable), .gang_mode(gang_mode),
    .oc_ack(oc_ack), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe_n(port_pin_oe_n), .port_pullup_en(port_pullup_en),
    .shared_power_control_oe_n(shared_power_control_oe_n),
    .upstream_power_detect(upstream_power_detect), .upstream_connect(upstream_connect),
    .upstream_reneg(upstream_reneg), .oc_flag(oc_flag));
`default_nettype wire

//--- verification/port_switch_model.sv
// Model of external port power switches with current monitors
`default_nettype none
module port_switch_model #(
    parameter int N = 7
) (
    input wire logic [N:1] pin_out,
    input wire logic [N:1] pin_oe_n,
    input wire logic [N:1] pullup_en,
    input wire logic [N:1] fault,
    input wire logic sh_out,
    input wire logic sh_oe_n,
    input wire logic sh_pullup,
    input wire logic sh_fault,
    output logic [N:1] pin_level,
    output logic sh_level,
    output logic [N:1] powered
);
    // Wired-AND: monitor pulls low; released pin without pull-up sinks to 0
    assign pin_level = ((~pin_oe_n & pin_out) | (pin_oe_n & pullup_en)) & ~fault;
    assign sh_level = ((~sh_oe_n & sh_out) | (sh_oe_n & sh_pullup)) & ~sh_fault;
    // Switch conducts on a high control level
    assign powered = pin_level;
endmodule
`default_nettype wire

//--- verification/port_power_overcurrent_ctl_tb.sv
// Self-checking bench for port power, overcurrent and upstream detect
`default_nettype none
module port_power_overcurrent_ctl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import port_power_pkg::*;
    // ----------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------
    typedef struct packed {logic [7:1] en; logic gang; logic [7:1] oe; logic sh;} row_type;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:1] port_enable = 7'h00;
    logic gang_mode = 1'h0;
    logic [7:1] oc_ack = 7'h00;
    logic [7:1] fault = 7'h00;
    logic sh_fault = 1'h0;
    logic detect = 1'h1;
    logic [7:1] pin_in, pin_out, pin_oe_n, pullup_en, oc_flag, powered;
    logic sh_in, sh_out, sh_oe_n, sh_pullup, connect, reneg, gang_oc;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    // Enable, gang, expected drive state, expected shared release
    row_type rows [7] = '{'{7'h00, 1'h0, 7'h00, 1'h0}, '{7'h7F, 1'h0, 7'h7F, 1'h0},
        '{7'h08, 1'h0, 7'h08, 1'h0}, '{7'h55, 1'h0, 7'h55, 1'h0},
        '{7'h01, 1'h1, 7'h00, 1'h1}, '{7'h00, 1'h1, 7'h00, 1'h0},
        '{7'h2A, 1'h0, 7'h2A, 1'h0}};
    port_power_overcurrent_ctl uut (.clk(clk), .nrst(nrst), .port_enable(port_enable),
        .gang_mode(gang_mode), .oc_ack(oc_ack), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n), .port_pullup_en(pullup_en),
        .shared_power_control_in(sh_in), .shared_power_control_out(sh_out),
        .shared_power_control_oe_n(sh_oe_n), .shared_pullup_en(sh_pullup),
        .upstream_power_detect(detect), .upstream_connect(connect),
        .upstream_reneg(reneg), .oc_flag(oc_flag), .gang_oc_flag(gang_oc));
    port_switch_model model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .fault(fault), .sh_out(sh_out), .sh_oe_n(sh_oe_n),
        .sh_pullup(sh_pullup), .sh_fault(sh_fault), .pin_level(pin_in),
        .sh_level(sh_in), .powered(powered));
    // Free-running core clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Hang guard, well above the planned run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits k edges, then lets their updates settle
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------
    // Main sequence
    // ----------------------------------------------------
    initial begin
        step(2);
        check({1'h0, pin_oe_n}, 8'h00);
        check({1'h0, oc_flag}, 8'h00);
        @(posedge clk) nrst <= 1'h1;
        foreach (rows[i]) begin
            @(posedge clk);
            port_enable <= rows[i].en;
            gang_mode <= rows[i].gang;
            step(2);
            check({1'h0, pin_oe_n}, {1'h0, rows[i].oe});
            check({1'h0, powered}, {1'h0, rows[i].oe});
            check({1'h0, pullup_en}, {1'h0, rows[i].oe});
            check({7'h00, sh_oe_n}, {7'h00, rows[i].sh});
        end
        // Port 7 off: its monitor pulling low must be ignored
        @(posedge clk) port_enable <= 7'h3F;
        step(2);
        @(posedge clk) fault <= 7'h50;
        step(4);
        check({1'h0, oc_flag}, 8'h10);
        // Ack while the fault stays: set wins
        @(posedge clk) oc_ack <= 7'h7F;
        @(posedge clk) oc_ack <= 7'h00;
        step(2);
        check({1'h0, oc_flag}, 8'h10);
        @(posedge clk) fault <= 7'h00;
        step(3);
        @(posedge clk) oc_ack <= 7'h10;
        @(posedge clk) oc_ack <= 7'h00;
        step(2);
        check({1'h0, oc_flag}, 8'h00);
        // Ganged: shared pin carries power and senses overcurrent
        @(posedge clk);
        gang_mode <= 1'h1;
        port_enable <= 7'h7F;
        sh_fault <= 1'h1;
        step(5);
        check({1'h0, pin_oe_n}, 8'h00);
        check({7'h00, gang_oc}, 8'h01);
        check({6'h00, sh_out, sh_pullup}, 8'h01);
        @(posedge clk) sh_fault <= 1'h0;
        step(3);
        @(posedge clk) oc_ack <= 7'h01;
        @(posedge clk) oc_ack <= 7'h00;
        step(2);
        check({7'h00, gang_oc}, 8'h00);
        @(posedge clk);
        gang_mode <= 1'h0;
        port_enable <= 7'h2A;
        step(2);
        check({6'h00, connect, reneg}, 8'h02);
        @(posedge clk) detect <= 1'h0;
        step(5);
        check({6'h00, connect, reneg}, 8'h00);
        // Toggle back up: renegotiate without touching ports
        @(posedge clk) detect <= 1'h1;
        n = 0;
        while (reneg !== 1'h1 && n < 10) begin
            step(1);
            n++;
        end
        n = 0;
        while (reneg === 1'h1 && n < 40) begin
            step(1);
            n++;
        end
        check(8'(n), 8'(RENEG_CYC));
        check({7'h00, connect}, 8'h01);
        check({1'h0, pin_oe_n}, 8'h2A);
        conclude();
    end
endmodule
`default_nettype wire
